// ===== bench/tb_uart_fifo_control.sv
// self-checking bench for the uart fifo control block
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_control;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, md = 1'b0, stall = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o, rx_data_irq_o, rx_dma_req_o, tx_dma_req_o;
   logic [7:0] tx_data_o, rx_data_i;
   logic [2:0] rx_err_i;
   int err_total = 0, num_checks = 0;
   // row: code [8:7], byte count [6:2], rx trigger [1], tx dma [0]
   logic [8:0] rows [12] = '{9'h001, 9'h007, 9'h00a, 9'h08d, 9'h093, 9'h096,
      9'h11d, 9'h123, 9'h126, 9'h1b5, 9'h1bb, 9'h1be};
   always #2.5 clk_i = ~clk_i;
   ufc_top ufc_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .modem_ctrl_multidrop_i(md), .tx_valid_o, .tx_data_o, .tx_ready_i, .rx_valid_i,
      .rx_data_i, .rx_err_i, .rx_ready_o, .rx_data_irq_o, .rx_dma_req_o, .tx_dma_req_o);
   ufc_peer ufc_peer_inst (.clk_i, .stall_i(stall), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
      .rx_data_o(rx_data_i), .rx_err_o(rx_err_i), .rx_ready_i(rx_ready_o));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      // no limit of its own: a hung transfer is ended by the watchdog
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic rx_push(input int n);
      for (int k = 1; k <= n; k++) ufc_peer_inst.q.push_back({k[2:0], k[7:0]});
      // one byte a cycle while there is room, then the request lag
      repeat (n + 8) @(posedge clk_i);
   endtask
   task automatic drain;
      stall <= 1'b0;
      repeat (40) @(posedge clk_i);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      wrap_up;
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, 8'h08, 0);
      chk(q, 0);
      chk({tx_dma_req_o, rx_data_irq_o}, 0);
      $display("reset test done");
      for (int r = 0; r < 12; r++) begin
         drain;
         bus(1, 8'h08, {rows[r][8:7], 6'h0f});
         stall <= 1'b1;
         // the first byte sits in the holding stage, so one extra write
         repeat (rows[r][6:2] + 1) bus(1, 8'h00, r);
         rx_push(rows[r][6:2]);
         chk(rx_data_irq_o, rows[r][1]);
         chk(rx_dma_req_o, rows[r][1]);
         chk(tx_dma_req_o, rows[r][0]);
         chk({tx_valid_o, tx_data_o}, {1'b1, r[7:0]});
         bus(0, 8'h20, 0);
         chk(q[12:8], rows[r][6:2]);
         chk(q[4:0], rows[r][6:2]);
         $display("row %0d done", r);
      end
      bus(0, 8'h00, 0);
      chk(q, 32'h101);
      bus(1, 8'h08, 32'hc9);
      bus(0, 8'h20, 0);
      chk(q[12:8], 14);
      chk(q[4:0], 15);
      md <= 1'b1;
      bus(1, 8'h08, 32'h01);
      bus(0, 8'h08, 0);
      chk(q[7:6], 2'b10);
      md <= 1'b0;
      bus(0, 8'h08, 0);
      chk(q[7:6], 2'b11);
      wb_sel_i <= 4'he;
      bus(1, 8'h08, 32'h00);
      wb_sel_i <= 4'hf;
      bus(0, 8'h08, 0);
      chk(q[7:6], 2'b11);
      $display("flush and mode tests done");
      drain;
      bus(1, 8'h08, 32'h07);
      bus(1, 8'h08, 32'hc8);
      stall <= 1'b1;
      rx_push(2);
      repeat (2) bus(1, 8'h00, 8'h5a);
      repeat (3) @(posedge clk_i);
      chk({rx_data_irq_o, rx_dma_req_o, tx_dma_req_o}, 3'b110);
      chk({tx_valid_o, tx_data_o}, 9'h15a);
      chk(rx_ready_o, 0);
      bus(0, 8'h20, 0);
      chk(q[12:8], 1);
      bus(1, 8'h08, 32'h01);
      repeat (3) @(posedge clk_i);
      chk({rx_data_irq_o, rx_dma_req_o, tx_dma_req_o}, 3'b100);
      bus(0, 8'hfc, 0);
      chk(q, 0);
      $display("one-deep and dma tests done");
      // a reset in mid-run must drop every setting and empty both fifos
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, 8'h08, 0);
      chk(q, 0);
      bus(0, 8'h20, 0);
      chk(q, 0);
      chk({tx_valid_o, rx_data_irq_o, rx_dma_req_o, tx_dma_req_o}, 0);
      $display("mid-run reset test done");
      wrap_up;
   end
endmodule
`default_nettype wire

// ===== bench/ufc_peer.sv
// far-side model: tx shifter with stall and rx byte source
`timescale 1ns/1ps
`default_nettype none
module ufc_peer (
   input wire logic clk_i,
   input wire logic stall_i,
   output logic tx_ready_o,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic [2:0] rx_err_o,
   input wire logic rx_ready_i
);
   // bytes waiting to go in, error bits above data
   logic [10:0] q[$];
   initial {tx_ready_o, rx_valid_o, rx_err_o, rx_data_o} = 13'h0000;
   always @(posedge clk_i) begin
      tx_ready_o <= !stall_i;
      if (rx_valid_o && rx_ready_i) begin
         q.delete(0);
      end
      if (q.size() > 0) begin
         rx_valid_o <= 1'b1;
         {rx_err_o, rx_data_o} <= q[0];
      end else begin
         // idle lines toggle so a stale byte never passes for data
         rx_valid_o <= 1'b0;
         {rx_err_o, rx_data_o} <= ~{rx_err_o, rx_data_o};
      end
   end
endmodule
`default_nettype wire

// ===== bench/ufc_top_asserts.sv
// port checker for the uart fifo control block
`timescale 1ns/1ps
`default_nettype none
module ufc_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic modem_ctrl_multidrop_i,
   input wire logic tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic rx_data_irq_o,
   input wire logic rx_dma_req_o,
   input wire logic tx_dma_req_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] ctl;
   wire logic rd = wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;
   wire logic [1:0] exp_state = !ctl[0] ? 2'b00 : (modem_ctrl_multidrop_i ? 2'b10 : 2'b11);
   // a write in flight may carry a tx flush, which legally drops the held byte
   wire logic wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
   ////////////////////////////////////////////////////////////
   // shadow of the write-only settings, taken at the same edge
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctl <= 8'h00;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h08 && wb_sel_i[0]) begin
         ctl <= wb_dat_i[7:0];
      end
   end
   ////////////////////////////////////////////////////////////
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_adr_i != 8'h00 |=> wb_ack_o)
      else $error("ack missing");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   reserved_zero_a: assert property (rd |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[5:0] == 6'h00)
      else $error("reserved bits set");
   queue_state_a: assert property (rd |-> wb_dat_o[7:6] == exp_state)
      else $error("queue state wrong");
   dma_off_a: assert property (!ctl[3] && $past(!ctl[3]) |-> !rx_dma_req_o && !tx_dma_req_o)
      else $error("dma request while off");
   dma_irq_a: assert property (rx_dma_req_o |-> rx_data_irq_o)
      else $error("rx dma without trigger");
   tx_hold_a: assert property (tx_valid_o && !tx_ready_i && !wr_req |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx byte dropped");
endmodule
bind ufc_top ufc_chk ufc_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .modem_ctrl_multidrop_i, .tx_valid_o, .tx_data_o, .tx_ready_i,
   .rx_data_irq_o, .rx_dma_req_o, .tx_dma_req_o);
`default_nettype wire

// ===== design/ufc_fifo.v
// flip-flop fifo with flush and a one-deep holding mode
`timescale 1ns/1ps
`default_nettype none
module ufc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_i,
   input wire rst_i,
   input wire flush_i,
   input wire one_deep_i,
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output reg in_ready_o,
   output wire out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input wire out_ready_i,
   output reg [AW:0] level_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   wire push;
   wire pop;
   wire [AW:0] cap;
   wire [AW:0] next_level;

   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_valid_o = (level_o != {(AW+1){1'b0}});
   assign out_data_o = mem[rd_ptr];
   assign cap = one_deep_i ? {{AW{1'b0}}, 1'b1} : DEPTH[AW:0];
   assign next_level = level_o + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   // ready is registered from the next level against the current cap, so one push can still pass in the cycle after the cap drops
   always @(posedge clk_i) begin
      if (rst_i || flush_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         level_o <= {(AW+1){1'b0}};
         in_ready_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
         end
         level_o <= next_level;
         in_ready_o <= (next_level < cap);
      end
   end

   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// ===== design/ufc_regs.vh
// register map, field positions, reset values and trigger levels of the uart fifo control block
`ifndef UFC_REGS_VH
`define UFC_REGS_VH

// word indices, byte address is four times the index
`define UFC_IDX_DATA 6'h00
`define UFC_IDX_CTRL 6'h02
`define UFC_IDX_STAT 6'h08

// fifo_control write fields
`define UFC_F_QUEUE_ON 0
`define UFC_F_RX_FLUSH 1
`define UFC_F_TX_FLUSH 2
`define UFC_F_DMA_ON 3
`define UFC_F_THR_LO 6
`define UFC_F_THR_HI 7

// queue_state read codes
`define UFC_QS_OFF 2'b00
`define UFC_QS_RX_OFF 2'b10
`define UFC_QS_ON 2'b11

// trigger codes and fill levels
`define UFC_RX_TX_THRESHOLD_1 2'b00
`define UFC_RX_TX_THRESHOLD_4 2'b01
`define UFC_RX_TX_THRESHOLD_8 2'b10
`define UFC_RX_TX_THRESHOLD_14 2'b11
`define UFC_LVL_1 5'h01
`define UFC_LVL_4 5'h04
`define UFC_LVL_8 5'h08
`define UFC_LVL_14 5'h0e
`define UFC_LVL_RX_OFF 5'h01
`define UFC_LVL_TX_OFF 5'h00

// status word fields
`define UFC_S_TX_LVL 0
`define UFC_S_RX_LVL 8
`define UFC_S_TX_DMA 16
`define UFC_S_RX_DMA 17
`define UFC_S_RX_IRQ 18
`define UFC_S_TX_BUSY 19
`define UFC_S_RX_AVAIL 20
`define UFC_S_DMA_ON 21
`define UFC_S_THR_LO 22
`define UFC_S_THR_HI 23

// byte lane of control fields and tx data, word select in the byte address
`define UFC_LANE_LO 0
`define UFC_LANE_HI 7
`define UFC_ADR_IDX_LO 2
`define UFC_ADR_IDX_HI 7

// reset values
`define UFC_RST_BYTE 8'h00
`define UFC_RST_THR 2'b00
`define UFC_RST_BIT 1'b0
`define UFC_ZERO32 32'h0000_0000

`endif

// ===== design/ufc_rx_tx_threshold.v
// trigger level decode and fill comparison for one fifo
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.vh"
module ufc_rx_tx_threshold (
   input wire [1:0] code_i,
   input wire deep_i,
   input wire [4:0] off_level_i,
   input wire [4:0] level_i,
   output wire at_least_o,
   output wire at_most_o
);
   reg [4:0] thr;

   always @* begin
      if (!deep_i) begin
         thr = off_level_i;
      end else begin
         case (code_i)
            `UFC_RX_TX_THRESHOLD_1: thr = `UFC_LVL_1;
            `UFC_RX_TX_THRESHOLD_4: thr = `UFC_LVL_4;
            `UFC_RX_TX_THRESHOLD_8: thr = `UFC_LVL_8;
            `UFC_RX_TX_THRESHOLD_14: thr = `UFC_LVL_14;
            default: thr = `UFC_LVL_1;
         endcase
      end
   end

   assign at_least_o = (level_i >= thr);
   assign at_most_o = (level_i <= thr);
endmodule
`default_nettype wire

// ===== design/ufc_top.v
// uart fifo control: control register, tx and rx fifos, triggers and dma requests
//
// What this block does
// - code 00: rx trigger 1, tx at most 1
// - code 01: rx trigger 4, tx at most 4
// - code 10: rx trigger 8, tx at most 8
// - code 11: rx trigger 14, tx at most 14
// - trigger field applies only with fifos enabled
// - dma requests only while dma enable set, registered one cycle behind it
// - tx flush empties tx fifo, resets pointers
// - rx flush empties data and error fifo
// - writing zero to flush bits changes nothing
// - enable clear: one-byte holding buffers both ways
// - enable set: fifos on, rx off in multidrop
// - control fields write-only, reset zero, reserved zero
// - queue state reads 00, 10 or 11
`timescale 1ns/1ps
`default_nettype none
`include "ufc_regs.vh"
module ufc_top #(
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter ERR_W = 3
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire modem_ctrl_multidrop_i,
   output reg tx_valid_o,
   output reg [7:0] tx_data_o,
   input wire tx_ready_i,
   input wire rx_valid_i,
   input wire [7:0] rx_data_i,
   input wire [ERR_W-1:0] rx_err_i,
   output wire rx_ready_o,
   output reg rx_data_irq_o,
   output reg rx_dma_req_o,
   output reg tx_dma_req_o
);

   ////////////////////////////////////////////////////////////////////////
   // internal copies of the write-only settings

   reg queue_on;
   reg dma_on;
   reg [1:0] rx_tx_threshold;
   reg tx_flush;
   reg rx_flush;

   wire [1:0] queue_state;
   wire tx_deep;
   wire rx_deep;

   ////////////////////////////////////////////////////////////////////////
   // fifo wires

   wire tx_in_ready;
   wire tx_out_valid;
   wire [7:0] tx_out_data;
   wire tx_pop;
   wire [AW:0] tx_level;

   wire rx_out_valid;
   wire [ERR_W+7:0] rx_out_data;
   wire rx_pop;
   wire [AW:0] rx_level;

   wire rx_hit;
   wire tx_hit;

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   wire [5:0] idx;
   wire req;
   wire hit_data;
   wire hit_ctrl;
   wire hit_stat;
   wire tx_push_req;
   wire take;
   wire ctrl_wr;
   wire data_rd;
   reg [31:0] next_dat;
   reg [31:0] status_word;

   assign idx = wb_adr_i[`UFC_ADR_IDX_HI:`UFC_ADR_IDX_LO];
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_data = (idx == `UFC_IDX_DATA);
   assign hit_ctrl = (idx == `UFC_IDX_CTRL);
   assign hit_stat = (idx == `UFC_IDX_STAT);

   // a data write into a full tx fifo waits for room instead of dropping
   assign tx_push_req = req & wb_we_i & hit_data & wb_sel_i[0];
   assign take = req & ~(tx_push_req & ~tx_in_ready);
   assign ctrl_wr = take & wb_we_i & hit_ctrl & wb_sel_i[0];
   assign data_rd = take & ~wb_we_i & hit_data;

   ////////////////////////////////////////////////////////////////////////
   // mode selection

   assign tx_deep = queue_on;
   assign rx_deep = queue_on & ~modem_ctrl_multidrop_i;

   assign queue_state = ~queue_on ? `UFC_QS_OFF :
                        (modem_ctrl_multidrop_i ? `UFC_QS_RX_OFF : `UFC_QS_ON);

   ////////////////////////////////////////////////////////////////////////
   // control register

   always @(posedge clk_i) begin
      if (rst_i) begin
         queue_on <= `UFC_RST_BIT;
         dma_on <= `UFC_RST_BIT;
         rx_tx_threshold <= `UFC_RST_THR;
         tx_flush <= `UFC_RST_BIT;
         rx_flush <= `UFC_RST_BIT;
      end else begin
         // flushes last one cycle and are never stored
         tx_flush <= 1'b0;
         rx_flush <= 1'b0;
         if (ctrl_wr) begin
            queue_on <= wb_dat_i[`UFC_F_QUEUE_ON];
            dma_on <= wb_dat_i[`UFC_F_DMA_ON];
            rx_tx_threshold <= wb_dat_i[`UFC_F_THR_HI:`UFC_F_THR_LO];
            // the enable written in the same word decides validity,
            // a zero bit leaves the fifo alone
            tx_flush <= wb_dat_i[`UFC_F_TX_FLUSH] & wb_dat_i[`UFC_F_QUEUE_ON];
            rx_flush <= wb_dat_i[`UFC_F_RX_FLUSH] & wb_dat_i[`UFC_F_QUEUE_ON];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status word: software cannot read the write-only fields back,
   // so the dma enable, the trigger code and the fill levels show here instead

   always @* begin
      status_word = `UFC_ZERO32;
      status_word[`UFC_S_TX_LVL+AW:`UFC_S_TX_LVL] = tx_level;
      status_word[`UFC_S_RX_LVL+AW:`UFC_S_RX_LVL] = rx_level;
      status_word[`UFC_S_TX_DMA] = tx_dma_req_o;
      status_word[`UFC_S_RX_DMA] = rx_dma_req_o;
      status_word[`UFC_S_RX_IRQ] = rx_data_irq_o;
      status_word[`UFC_S_TX_BUSY] = tx_valid_o;
      status_word[`UFC_S_RX_AVAIL] = rx_out_valid;
      status_word[`UFC_S_DMA_ON] = dma_on;
      status_word[`UFC_S_THR_HI:`UFC_S_THR_LO] = rx_tx_threshold;
   end

   ////////////////////////////////////////////////////////////////////////
   // read data mux, write-only fields read as zero

   always @* begin
      next_dat = `UFC_ZERO32;
      if (hit_ctrl) begin
         next_dat[`UFC_F_THR_HI:`UFC_F_THR_LO] = queue_state;
      end else if (hit_data) begin
         if (rx_out_valid) begin
            next_dat[ERR_W+7:0] = rx_out_data;
         end
      end else if (hit_stat) begin
         next_dat = status_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer, unmapped words ack with zero

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `UFC_ZERO32;
      end else begin
         wb_ack_o <= take;
         if (take && !wb_we_i) begin
            wb_dat_o <= next_dat;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit fifo and output holding stage

   ufc_fifo #(
      .WIDTH(8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_tx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(tx_flush),
      .one_deep_i(~tx_deep),
      .in_valid_i(tx_push_req & take),
      .in_data_i(wb_dat_i[`UFC_LANE_HI:`UFC_LANE_LO]),
      .in_ready_o(tx_in_ready),
      .out_valid_o(tx_out_valid),
      .out_data_o(tx_out_data),
      .out_ready_i(tx_pop),
      .level_o(tx_level)
   );

   // the holding stage keeps tx_data_o on a flop; it is one byte beyond the fifo
   assign tx_pop = tx_out_valid & (~tx_valid_o | tx_ready_i) & ~tx_flush;

   always @(posedge clk_i) begin
      if (rst_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o <= `UFC_RST_BYTE;
      end else if (tx_flush) begin
         tx_valid_o <= 1'b0;
      end else if (tx_pop) begin
         tx_valid_o <= 1'b1;
         tx_data_o <= tx_out_data;
      end else if (tx_ready_i) begin
         tx_valid_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive fifo, error bits travel beside each byte

   ufc_fifo #(
      .WIDTH(ERR_W + 8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_rx_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(rx_flush),
      .one_deep_i(~rx_deep),
      .in_valid_i(rx_valid_i),
      .in_data_i({rx_err_i, rx_data_i}),
      .in_ready_o(rx_ready_o),
      .out_valid_o(rx_out_valid),
      .out_data_o(rx_out_data),
      .out_ready_i(rx_pop),
      .level_o(rx_level)
   );

   assign rx_pop = data_rd & rx_out_valid;

   ////////////////////////////////////////////////////////////////////////
   // triggers

   ufc_rx_tx_threshold u_rx_rx_tx_threshold (
      .code_i(rx_tx_threshold),
      .deep_i(rx_deep),
      .off_level_i(`UFC_LVL_RX_OFF),
      .level_i(rx_level),
      .at_least_o(rx_hit),
      .at_most_o()
   );

   ufc_rx_tx_threshold u_tx_rx_tx_threshold (
      .code_i(rx_tx_threshold),
      .deep_i(tx_deep),
      .off_level_i(`UFC_LVL_TX_OFF),
      .level_i(tx_level),
      .at_least_o(),
      .at_most_o(tx_hit)
   );

   ////////////////////////////////////////////////////////////////////////
   // interrupt condition and dma requests, one cycle behind the levels

   always @(posedge clk_i) begin
      if (rst_i) begin
         rx_data_irq_o <= 1'b0;
         rx_dma_req_o <= 1'b0;
         tx_dma_req_o <= 1'b0;
      end else begin
         rx_data_irq_o <= rx_hit;
         rx_dma_req_o <= rx_hit & dma_on;
         tx_dma_req_o <= tx_hit & dma_on;
      end
   end

endmodule
`default_nettype wire
